// ===== dv/timer8_core_bench.sv
// Self-checking bench for the 8-bit timer/counter top.
// Assumes one APB master (this bench) and a count pin driven by the bench.
`timescale 1ns/1ns
module timer8_core_bench;
    import timer8_pkg::*;
    typedef struct packed {logic err; logic [31:0] dat; logic [31:0] msk;} note_s;
    logic        core_clk_i, rst_b_i, psel, penable, pwrite, pin, gie, vt_ovf, vt_a, vt_b;
    logic [31:0] paddr, pwdata, prdata;
    logic        pready, pslverr, wave_a, wave_b, drv_a, drv_b, irq_o, irq_a, irq_b;
    note_s       notes[$];
    note_s       cur;
    int          n_mismatch, cmp_count, cycles;
    logic [7:0]  v;
    logic [4:0]  ofs[7] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_COUNTER, OFS_CMP_A, OFS_CMP_B,
                            OFS_IRQ_MASK, OFS_FLAGS};

    timer8_core u_dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin_i(pin), .global_irq_enable_i(gie),
        .vector_taken_ovf_i(vt_ovf), .vector_taken_cmpa_i(vt_a), .vector_taken_cmpb_i(vt_b),
        .wave_out_a_o(wave_a), .wave_out_b_o(wave_b), .wave_drive_a_o(drv_a),
        .wave_drive_b_o(drv_b), .irq_overflow_o(irq_o), .irq_compare_a_o(irq_a),
        .irq_compare_b_o(irq_b)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ********************************
    // Checking and closing
    // ********************************
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t output %b expected %b", $time, got, exp);
        end
    endtask : chk

    // Answers are judged by this watcher, not by the driver
    always @(posedge core_clk_i) begin
        if (pready === 1'b1) begin
            cmp_count++;
            if (notes.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t answer with no request", $time);
            end else begin
                cur = notes.pop_front();
                if ((prdata & cur.msk) !== cur.dat || pslverr !== cur.err) begin
                    n_mismatch++;
                    $display("[FAIL] %0t read %h err %b, expected %h err %b", $time,
                             prdata, pslverr, cur.dat, cur.err);
                end
            end
        end
    end

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("[FAIL] %0t run did not finish", $time);
            wrap_up();
        end
    end

    // ********************************
    // Bus and pin drivers
    // ********************************
    task automatic apb(input logic wr, input logic [4:0] a, input logic [7:0] wd,
                       input logic [7:0] ed, input logic [7:0] m, input logic ee);
        notes.push_back('{ee, {24'h000000, ed & m}, {24'hFFFFFF, m}});
        @(posedge core_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {27'h0000000, a};
        pwdata  <= {24'h000000, wd};
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 8'h00, 8'h00, 1'b0);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        apb(1'b0, a, 8'h00, e, m, 1'b0);
    endtask : rd

    // Each pulse is slower than the pin limit of half the system clock
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            pin <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            pin <= 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
    endtask : pulse

    task automatic hit(input logic [2:0] s);
        @(posedge core_clk_i);
        {vt_b, vt_a, vt_ovf} <= s;
        @(posedge core_clk_i);
        {vt_b, vt_a, vt_ovf} <= 3'b000;
        repeat (3) @(posedge core_clk_i);
    endtask : hit

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        {rst_b_i, psel, penable, pwrite, pin, gie, vt_ovf, vt_a, vt_b} = '0;
        paddr = '0;
        pwdata = '0;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        void'($urandom(32'h7E24C32D));
        for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00);
        wr(OFS_CTRL_A, 8'hFF);
        rd(OFS_CTRL_A, 8'hF3);
        wr(OFS_CTRL_B, 8'h3F);
        rd(OFS_CTRL_B, 8'h0F);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_IRQ_MASK, 8'hFF);
        rd(OFS_IRQ_MASK, 8'h07);
        wr(OFS_FLAGS, 8'hFF);
        rd(OFS_FLAGS, 8'h00);
        apb(1'b0, 5'h1C, 8'h00, 8'h00, 8'hFF, 1'b1);
        apb(1'b1, 5'h01, 8'hAA, 8'h00, 8'h00, 1'b1);
        for (int i = 2; i < 5; i++) begin
            v = 8'($urandom);
            wr(ofs[i], v);
            rd(ofs[i], v);
        end
        gie <= 1'b1;
        wr(OFS_CMP_A, 8'h05);
        wr(OFS_CMP_B, 8'h08);
        wr(OFS_CTRL_A, 8'h70);
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_IRQ_MASK, 8'h07);
        wr(OFS_CTRL_B, CS_EXT_RISE);
        pulse(6);
        rd(OFS_FLAGS, 8'h02);
        chk(wave_a, 1'b1);
        chk(drv_a, 1'b1);
        chk(drv_b, 1'b1);
        chk(irq_a, 1'b1);
        chk(irq_b, 1'b0);
        pulse(3);
        rd(OFS_FLAGS, 8'h06);
        chk(wave_b, 1'b1);
        chk(irq_b, 1'b1);
        rd(OFS_COUNTER, 8'h09);
        wr(OFS_FLAGS, 8'h02);
        rd(OFS_FLAGS, 8'h04);
        hit(3'b100);
        rd(OFS_FLAGS, 8'h00);
        chk(irq_b, 1'b0);
        wr(OFS_CTRL_B, CS_EXT_FALL);
        @(posedge core_clk_i);
        pin <= 1'b1;
        rd(OFS_COUNTER, 8'h09);
        pin <= 1'b0;
        rd(OFS_COUNTER, 8'h0A);
        wr(OFS_CTRL_B, CS_STOP);
        pulse(2);
        rd(OFS_COUNTER, 8'h0A);
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_CTRL_B, CS_DIV1);
        wr(OFS_CTRL_B, CS_STOP);
        rd(OFS_COUNTER, 8'h04);
        wr(OFS_CTRL_B, 8'h80);
        chk(wave_a, 1'b0);
        wr(OFS_CTRL_A, 8'h60);
        wr(OFS_CTRL_B, 8'h40);
        chk(wave_b, 1'b0);
        rd(OFS_FLAGS, 8'h00);
        rd(OFS_CTRL_B, 8'h00);
        wr(OFS_CMP_A, 8'h10);
        wr(OFS_COUNTER, 8'h10);
        wr(OFS_CTRL_B, CS_EXT_RISE);
        pulse(1);
        rd(OFS_FLAGS, 8'h00);
        rd(OFS_COUNTER, 8'h11);
        wr(OFS_COUNTER, 8'hFE);
        pulse(2);
        rd(OFS_FLAGS, 8'h01, 8'h01);
        chk(irq_o, 1'b1);
        gie <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk(irq_o, 1'b0);
        gie <= 1'b1;
        hit(3'b001);
        rd(OFS_FLAGS, 8'h00, 8'h01);
        wr(OFS_CTRL_B, CS_STOP);
        wr(OFS_CMP_A, 8'h03);
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_CTRL_A, 8'h62);
        wr(OFS_CTRL_B, CS_EXT_RISE);
        pulse(4);
        rd(OFS_COUNTER, 8'h00);
        rd(OFS_FLAGS, 8'h02);
        wr(OFS_FLAGS, 8'h07);
        pulse(2);
        wr(OFS_CTRL_B, 8'h87);
        rd(OFS_COUNTER, 8'h02);
        rd(OFS_FLAGS, 8'h00);
        wr(OFS_CTRL_B, CS_STOP);
        wr(OFS_CTRL_A, 8'h03);
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_CTRL_B, 8'h0F);
        pulse(4);
        rd(OFS_FLAGS, 8'h01, 8'h01);
        rd(OFS_COUNTER, 8'h00);
        hit(3'b010);
        rd(OFS_FLAGS, 8'h01);
        wr(OFS_CTRL_B, 8'h08);
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_CTRL_B, 8'h0F);
        pulse(6);
        rd(OFS_FLAGS, 8'h02);
        pulse(1);
        rd(OFS_FLAGS, 8'h03);
        rd(OFS_COUNTER, 8'h01);
        repeat (4) @(posedge core_clk_i);
        wrap_up();
    end
endmodule : timer8_core_bench

// ===== src/timer8_core.sv
// Top: 8-bit timer/counter with two compare channels and an APB slave.
// Assumes a synchronous count pin and one 250 MHz clock; 32-bit APB.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
module timer8_core
    import timer8_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        vector_taken_ovf_i,
    input  wire logic        vector_taken_cmpa_i,
    input  wire logic        vector_taken_cmpb_i,
    output logic             wave_out_a_o,
    output logic             wave_out_b_o,
    output logic             wave_drive_a_o,
    output logic             wave_drive_b_o,
    output logic             irq_overflow_o,
    output logic             irq_compare_a_o,
    output logic             irq_compare_b_o
);
    // ***********************************************************
    // State
    // ***********************************************************
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  counter;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic [7:0]  mask;
        logic [2:0]  flags;
        logic        down;
        logic        block_match;
        logic [31:0] rdata;
        logic        err;
        logic [2:0]  irq;
        logic        drv_a;
        logic        drv_b;
    } core_s;
    core_s st_reg, st_next;

    logic       tick;
    logic       wave_a, wave_b;
    logic [2:0] mode;
    logic [7:0] top;
    logic       acc, wr, rd;
    logic       pready_reg;
    logic [4:0] ofs;
    logic       mapped;
    logic       m_a, m_b, ovf;
    logic       force_a, force_b;
    logic       act_a, act_b;
    logic [2:0] set_f, clr_f;

    assign mode = {st_reg.ctrl_b[BIT_HI_MODE], st_reg.ctrl_a[1:0]}; // [R1]

    // ***********************************************************
    // Tick source and waveform channels
    // ***********************************************************
    timer8_tick_gen u_tick (
        .core_clk_i            (core_clk_i),
        .rst_b_i               (rst_b_i),
        .clock_source_select_i (st_reg.ctrl_b[2:0]),
        .external_count_pin_i  (external_count_pin_i),
        .tick_o                (tick)
    );

    timer8_wave_out u_wave_a (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .output_mode_i (st_reg.ctrl_a[7:6]),
        .act_i         (act_a),
        .wave_o        (wave_a)
    );

    timer8_wave_out u_wave_b (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .output_mode_i (st_reg.ctrl_a[5:4]),
        .act_i         (act_b),
        .wave_o        (wave_b)
    );

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    // The answer cycle keeps psel and penable high; acting on it again
    // would repeat a force strobe and toggle the pin back
    assign acc = psel && penable && !pready_reg;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign ofs = paddr[4:0];
    assign mapped = (paddr[31:5] == 27'h0) && (ofs[1:0] == 2'h0) && (ofs <= OFS_FLAGS);

    // ***********************************************************
    // Counting, compare and flags
    // ***********************************************************
    always_comb begin
        // TOP follows the mode; reserved modes take TOP = MAX as in normal mode
        case (mode) // [R2]
            MODE_CLR_MATCH, MODE_PC_CMPA, MODE_FAST_CMPA: top = st_reg.cmp_a;
            default:                                      top = MAX_VAL;
        endcase
        // Match is gated by the tick and blocked after a counter write
        m_a = tick && !st_reg.block_match && (st_reg.counter == st_reg.cmp_a); // [R14] [R13] [R21]
        m_b = tick && !st_reg.block_match && (st_reg.counter == st_reg.cmp_b); // [R14] [R13] [R21]
        case (mode) // [R3] [R19]
            MODE_PC_FF, MODE_PC_CMPA: ovf = tick && (st_reg.counter == BOTTOM_VAL) && st_reg.down;
            MODE_FAST_CMPA:           ovf = tick && (st_reg.counter == top);
            default:                  ovf = tick && (st_reg.counter == MAX_VAL);
        endcase
        force_a = wr && mapped && ofs == OFS_CTRL_B && pwdata[BIT_FORCE_A] && !is_pwm(mode); // [R5]
        force_b = wr && mapped && ofs == OFS_CTRL_B && pwdata[BIT_FORCE_B] && !is_pwm(mode); // [R5]
        // Only non-PWM matches drive the pins here; PWM tables are not modelled
        act_a = force_a || (m_a && !is_pwm(mode)); // [R5] [R20]
        act_b = force_b || (m_b && !is_pwm(mode)); // [R5] [R20]
    end

    always_comb begin
        st_next = st_reg;
        st_next.err = 1'b0;
        st_next.rdata = 32'h0;
        set_f = {m_b, m_a, ovf}; // [R16] [R18] [R19] [R6]
        clr_f = {vector_taken_cmpb_i, vector_taken_cmpa_i, vector_taken_ovf_i}; // [R17]

        // Count sequence
        if (tick) begin // [R21]
            case (mode)
                MODE_PC_FF, MODE_PC_CMPA: begin
                    if (!st_reg.down && st_reg.counter >= top) begin
                        st_next.down = 1'b1;
                        st_next.counter = st_reg.counter - 8'h01;
                    end else if (st_reg.down && st_reg.counter == BOTTOM_VAL) begin
                        st_next.down = 1'b0;
                        st_next.counter = st_reg.counter + 8'h01;
                    end else if (st_reg.down) begin
                        st_next.counter = st_reg.counter - 8'h01;
                    end else begin
                        st_next.counter = st_reg.counter + 8'h01;
                    end
                end
                MODE_CLR_MATCH, MODE_FAST_CMPA: begin
                    // Wrap on the tick after the TOP match; forces never reach here
                    if (st_reg.counter == top) begin // [R22] [R6]
                        st_next.counter = BOTTOM_VAL;
                    end else begin
                        st_next.counter = st_reg.counter + 8'h01;
                    end
                    st_next.down = 1'b0;
                end
                default: begin
                    st_next.counter = st_reg.counter + 8'h01;
                    st_next.down = 1'b0;
                end
            endcase
            st_next.block_match = 1'b0;
        end

        // Register writes and reads
        if (wr) begin
            if (mapped) begin
                case (ofs)
                    OFS_CTRL_A:   st_next.ctrl_a = pwdata[7:0] & CTRL_A_MASK; // [R4]
                    OFS_CTRL_B:   st_next.ctrl_b = pwdata[7:0] & CTRL_B_MASK; // [R4] [R7]
                    OFS_COUNTER: begin
                        st_next.counter = pwdata[7:0]; // [R12]
                        st_next.block_match = 1'b1; // [R13]
                    end
                    OFS_CMP_A:    st_next.cmp_a = pwdata[7:0];
                    OFS_CMP_B:    st_next.cmp_b = pwdata[7:0];
                    OFS_IRQ_MASK: st_next.mask = pwdata[7:0] & IRQ_MASK_BITS; // [R4] [R15]
                    OFS_FLAGS:    clr_f = clr_f | pwdata[2:0]; // [R17]
                    default:      st_next.err = 1'b0;
                endcase
            end else begin
                st_next.err = 1'b1;
            end
        end else if (rd) begin
            if (mapped) begin
                case (ofs)
                    OFS_CTRL_A:   st_next.rdata = {24'h0, st_reg.ctrl_a};
                    OFS_CTRL_B:   st_next.rdata = {24'h0, st_reg.ctrl_b}; // [R7]
                    OFS_COUNTER:  st_next.rdata = {24'h0, st_reg.counter}; // [R12]
                    OFS_CMP_A:    st_next.rdata = {24'h0, st_reg.cmp_a};
                    OFS_CMP_B:    st_next.rdata = {24'h0, st_reg.cmp_b};
                    OFS_IRQ_MASK: st_next.rdata = {24'h0, st_reg.mask};
                    OFS_FLAGS:    st_next.rdata = {29'h0, st_reg.flags};
                    default:      st_next.rdata = 32'h0;
                endcase
            end else begin
                st_next.err = 1'b1;
            end
        end

        // A new event wins over a clear in the same cycle
        st_next.flags = (st_reg.flags & ~clr_f) | set_f; // [R17]
        st_next.irq = st_next.flags & st_next.mask[2:0] & {3{global_irq_enable_i}}; // [R15]
        st_next.drv_a = (st_next.ctrl_a[7:6] != 2'h0); // [R20]
        st_next.drv_b = (st_next.ctrl_a[5:4] != 2'h0);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    // One wait state: pready rises in the second access cycle with the data
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
        end
    end

    assign pready = pready_reg;
    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.err;
    assign wave_out_a_o = wave_a;
    assign wave_out_b_o = wave_b;
    assign wave_drive_a_o = st_reg.drv_a;
    assign wave_drive_b_o = st_reg.drv_b;
    assign irq_overflow_o = st_reg.irq[BIT_OVF];
    assign irq_compare_a_o = st_reg.irq[BIT_CMPA];
    assign irq_compare_b_o = st_reg.irq[BIT_CMPB];

    // ***********************************************************
    // Checks
    // ***********************************************************
    chk_no_tick_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (!tick && !wr) |=> $stable(st_reg.counter)) else $error("counter moved without tick"); // [R21]
    chk_cmpb_flag_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        m_b |=> st_reg.flags[BIT_CMPB]) else $error("compare B flag not set"); // [R16]
    chk_cmpa_flag_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        m_a |=> st_reg.flags[BIT_CMPA]) else $error("compare A flag not set"); // [R18]
    chk_counter_block: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (wr && mapped && ofs == OFS_COUNTER) |=> (!m_a && !m_b)) else $error("match after write"); // [R13]
    chk_force_keeps_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (force_a && !tick) |=> $stable(st_reg.counter)) else $error("force moved counter"); // [R6]
    chk_pc_bottom_ovf: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ovf && (mode == MODE_PC_FF || mode == MODE_PC_CMPA))
        |=> st_reg.flags[BIT_OVF]) else $error("overflow at BOTTOM missed"); // [R3]
    chk_force_no_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (force_a && !m_a && !st_reg.flags[BIT_CMPA] && !vector_taken_cmpa_i)
        |=> !st_reg.flags[BIT_CMPA]) else $error("force set flag"); // [R6]
    chk_ctc_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (tick && !wr && mode == MODE_CLR_MATCH && st_reg.counter == st_reg.cmp_a)
        |=> st_reg.counter == BOTTOM_VAL) else $error("clear-on-match wrap missed"); // [R22]
    chk_flag_w1c: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (wr && mapped && ofs == OFS_FLAGS && pwdata[BIT_OVF] && !ovf)
        |=> !st_reg.flags[BIT_OVF]) else $error("overflow flag not cleared"); // [R17]
    chk_ovf_normal: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (tick && mode == MODE_NORMAL && st_reg.counter == MAX_VAL)
        |=> st_reg.flags[BIT_OVF]) else $error("overflow at MAX missed"); // [R3]
    chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (st_reg.mask[7:3] == 5'h0) && (st_reg.ctrl_b[7:4] == 4'h0)) else $error("reserved bit set"); // [R4]
    chk_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !global_irq_enable_i |=> !irq_overflow_o) else $error("irq without global enable"); // [R15]
endmodule : timer8_core

// ===== src/timer8_pkg.sv
// Constants, register map and field layout of the 8-bit timer/counter.
// Assumes one 250 MHz system clock and an APB register port.
// Operation
// [R1] Mode is {high bit, low bits}; 0 normal TOP FF, 1 phase-correct TOP FF.
// [R2] Mode 2 clear-on-match, 3 fast FF, 5/7 TOP from compare A; 4,6 reserved.
// [R3] Overflow at MAX in 0,2,3; at BOTTOM in 1,5; at TOP in 7.
// [R4] Reserved bits ignore writes and read zero.
// [R5] Force bit 7/6 in non-PWM mode applies channel compare action now.
// [R6] Forced strobe sets no flag and never clears the counter.
// [R7] Force bits are write strobes only and read zero.
// [R8] Software writes zero force bits while a PWM mode is selected.
// [R9] Clock select 0 stops, 1 undivided, 2..5 divide by 8,64,256,1024.
// [R10] Clock select 6 counts falling pin edges, 7 rising pin edges.
// [R11] Pin edges count even while the pin is an output.
// [R12] Counter readable and writable by software at any time.
// [R13] Counter write suppresses compare matches on the next timer tick.
// [R14] Compare values compared continuously; equality drives flag and output; here the output only in non-PWM modes 0 and 2.
// [R15] Mask bits 2,1,0 gate flags with global enable onto requests.
// [R16] Flag bit 2 sets on compare B match.
// [R17] Flags clear on vector taken or written one; zero leaves them.
// [R18] Flag bit 1 sets on compare A match.
// [R19] Flag bit 0 sets on overflow at the mode's point.
// [R20] Non-PWM output codes: 01 toggle, 10 clear, 11 set, 00 disconnected.
// [R21] Count, compare and flag updates only on timer tick cycles.
// [R22] Clear-on-match counter returns to zero on the tick after TOP match.
package timer8_pkg;
    localparam logic [4:0] OFS_CTRL_A   = 5'h00;
    localparam logic [4:0] OFS_CTRL_B   = 5'h04;
    localparam logic [4:0] OFS_COUNTER  = 5'h08;
    localparam logic [4:0] OFS_CMP_A    = 5'h0C;
    localparam logic [4:0] OFS_CMP_B    = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    localparam logic [4:0] OFS_FLAGS    = 5'h18;

    localparam logic [7:0] CTRL_A_MASK  = 8'hF3;
    localparam logic [7:0] CTRL_B_MASK  = 8'h0F;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h07;
    localparam int         BIT_FORCE_A  = 7;
    localparam int         BIT_FORCE_B  = 6;
    localparam int         BIT_HI_MODE  = 3;
    localparam int         BIT_OVF      = 0;
    localparam int         BIT_CMPA     = 1;
    localparam int         BIT_CMPB     = 2;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] MAX_VAL      = 8'hFF;
    localparam logic [7:0] BOTTOM_VAL   = 8'h00;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int         PRESCALE_W = 10;

    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_PC_FF    = 3'h1;
    localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_FF  = 3'h3;
    localparam logic [2:0] MODE_PC_CMPA  = 3'h5;
    localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;

    function automatic logic is_pwm(input logic [2:0] mode);
        return !(mode == MODE_NORMAL || mode == MODE_CLR_MATCH);
    endfunction : is_pwm
endpackage : timer8_pkg

// ===== src/timer8_tick_gen.sv
// Timer tick source: free-running prescaler taps and external pin edges.
// Assumes the pin input is already synchronous to the system clock.
`timescale 1ns/1ns
module timer8_tick_gen
    import timer8_pkg::*;
#(
    parameter int PW = PRESCALE_W
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [2:0] clock_source_select_i,
    input  wire logic       external_count_pin_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [PW-1:0] pre;
        logic          pin_last;
        logic          tick;
    } tick_s;
    tick_s st_reg, st_next;
    logic rise, fall;

    always_comb begin
        st_next = st_reg;
        st_next.pre = st_reg.pre + 1'b1;
        st_next.pin_last = external_count_pin_i;
        // Pin is sampled regardless of its direction setting
        rise = external_count_pin_i & ~st_reg.pin_last; // [R11]
        fall = ~external_count_pin_i & st_reg.pin_last;
        case (clock_source_select_i) // [R9]
            CS_STOP:     st_next.tick = 1'b0;
            CS_DIV1:     st_next.tick = 1'b1;
            CS_DIV8:     st_next.tick = (st_reg.pre[2:0] == 3'h7);
            CS_DIV64:    st_next.tick = (st_reg.pre[5:0] == 6'h3F);
            CS_DIV256:   st_next.tick = (st_reg.pre[7:0] == 8'hFF);
            CS_DIV1024:  st_next.tick = (st_reg.pre == {PW{1'b1}});
            CS_EXT_FALL: st_next.tick = fall; // [R10]
            CS_EXT_RISE: st_next.tick = rise; // [R10]
            default:     st_next.tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;

    chk_stop_no_tick: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clock_source_select_i == CS_STOP) |=> !tick_o) else $error("tick while stopped"); // [R9]
endmodule : timer8_tick_gen

// ===== src/timer8_wave_out.sv
// One compare channel's waveform output bit.
// Assumes match and force are one-cycle pulses qualified upstream.
`timescale 1ns/1ns
module timer8_wave_out
    import timer8_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [1:0] output_mode_i,
    input  wire logic       act_i,
    output logic            wave_o
);
    typedef struct packed {
        logic wave;
    } wave_s;
    wave_s st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (act_i) begin
            case (output_mode_i) // [R20]
                OUT_TOGGLE: st_next.wave = ~st_reg.wave;
                OUT_CLEAR:  st_next.wave = 1'b0;
                OUT_SET:    st_next.wave = 1'b1;
                default:    st_next.wave = st_reg.wave;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wave_o = st_reg.wave;

    chk_set_code: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (act_i && output_mode_i == OUT_SET) |=> wave_o) else $error("set code missed"); // [R20]
endmodule : timer8_wave_out
